// ===== rtl/output_conditioning.sv
// Purpose: chooses proportional or two-state drive, input-error substitution, stop values, rate limits
// Assumes: measurement chain supplies measured and set values and input-error levels, PID supplies demands
// Notes: inputs other than reset_n synchronous to clock; registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps

module output_conditioning
  import outcond_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
)
(
  input wire logic clock, // 10 MHz system clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [outcond_pkg::ADDR_W-1:0] addr, // Register word index
  input wire logic [outcond_pkg::DATA_W-1:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic signed [15:0] measured_value, // Measured value
  input wire logic signed [15:0] set_value, // Set value
  input wire logic signed [15:0] pid_heat, // Proportional heat demand
  input wire logic signed [15:0] pid_cool, // Proportional cool demand
  input wire logic input_error_high, // Measured value past high error point
  input wire logic input_error_low, // Measured value past low error point
  input wire logic feedback_fitted, // Valve feedback input present
  input wire logic feedback_broken, // Valve feedback input broken
  output logic [outcond_pkg::DATA_W-1:0] rd_data, // Read data, cycle after read strobe
  output logic signed [15:0] heat_side_output, // Heat-side manipulated output
  output logic signed [15:0] cool_side_output, // Cool-side manipulated output
  output logic [15:0] derivative_gain, // Derivative gain to the PID term
  output logic valve_stop_follow, // Valve follows its at-stop action
  output logic irq // Level interrupt
);
  logic [CTRL_W-1:0] ctrl_q;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] mask_q;
  logic [15:0] dgain_q;
  logic [15:0] pb_heat_q;
  logic [15:0] gap_up_q;
  logic [15:0] gap_lo_q;
  logic [1:0] gap_set_q;
  logic [15:0] span_q;
  logic signed [15:0] err_mv_q;
  logic signed [15:0] stop_heat_q;
  logic signed [15:0] stop_cool_q;
  logic signed [15:0] manual_mv_q;
  logic [15:0] rate_q [4];
  logic [15:0] limit_q [4];
  logic [15:0] rd_data_q;
  logic [23:0] div_q;
  logic sample, on_q, err_q, run_q, suppress_q, follow_q;
  logic [1:0] err_side_q;
  logic run, manual, valve, err_now, subst, fb_ok, onoff_mode;
  logic [15:0] gap_up_eff, gap_lo_eff;
  logic [EV_W-1:0] events;
  logic signed [15:0] heat_target, cool_target;

  if (SAMPLE_CYCLES_P < 2 || SAMPLE_CYCLES_P >= (1 << 24))
    $error("SAMPLE_CYCLES_P out of range");

  // A gap left at reset follows 0.1 % of span for voltage and current inputs
  function automatic logic [15:0] gap_eff(input logic [15:0] g, input logic written, input logic analog,
                                           input logic [15:0] span);
    if (analog && !written)
      return span / GAP_SPAN_DIV;
    return g;
  endfunction

  function automatic logic wr_hit(input logic [4:0] index);
    return wr_en && addr == index;
  endfunction

  assign run = ctrl_q[CTRL_RUN];
  assign manual = ctrl_q[CTRL_MANUAL];
  assign valve = ctrl_q[CTRL_VALVE];
  assign fb_ok = feedback_fitted && !feedback_broken;
  assign onoff_mode = pb_heat_q == 16'h0000;
  assign gap_up_eff = gap_eff(gap_up_q, gap_set_q[0], ctrl_q[CTRL_ANALOG], span_q);
  assign gap_lo_eff = gap_eff(gap_lo_q, gap_set_q[1], ctrl_q[CTRL_ANALOG], span_q);
  assign err_now = (input_error_high && ctrl_q[CTRL_ACT_HIGH]) || (input_error_low && ctrl_q[CTRL_ACT_LOW]);
  // Substitution fires on the moment of detection, only in auto and running
  assign subst = run && run_q && !manual && err_now && !err_q && !suppress_q;
  assign events = {on_q && !onoff_mode, subst, input_error_low && !err_side_q[1], input_error_high && !err_side_q[0]};

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      div_q <= 24'h000000;
    else if (div_q == 24'(SAMPLE_CYCLES_P - 1))
      div_q <= 24'h000000;
    else
      div_q <= div_q + 24'h000001;
  end
  assign sample = div_q == 24'(SAMPLE_CYCLES_P - 1);

  // Control register; hardware entry into manual wins over a software write
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= '0;
    else
    begin
      if (wr_hit(REG_CTRL))
        ctrl_q <= wr_data[CTRL_W-1:0];
      if (subst)
        ctrl_q[CTRL_MANUAL] <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      manual_mv_q <= MANUAL_MV_RST;
    else if (subst)
      manual_mv_q <= err_mv_q;
    else if (wr_hit(REG_MANUAL_MV))
      manual_mv_q <= wr_data;
  end

  // Setting registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dgain_q <= DGAIN_RST;
      pb_heat_q <= PB_HEAT_RST;
      gap_up_q <= GAP_RST;
      gap_lo_q <= GAP_RST;
      gap_set_q <= 2'b00;
      span_q <= SPAN_RST;
      err_mv_q <= ERR_MV_RST;
      stop_heat_q <= STOP_MV_RST;
      stop_cool_q <= STOP_MV_RST;
      mask_q <= '0;
    end
    else if (wr_en)
    begin
      unique case (addr)
        REG_DGAIN: dgain_q <= wr_data < DGAIN_MIN ? DGAIN_MIN : (wr_data > DGAIN_MAX ? DGAIN_MAX : wr_data);
        REG_PB_HEAT: pb_heat_q <= wr_data;
        REG_GAP_UP:
        begin
          gap_up_q <= wr_data;
          gap_set_q[0] <= 1'b1;
        end
        REG_GAP_LO:
        begin
          gap_lo_q <= wr_data;
          gap_set_q[1] <= 1'b1;
        end
        REG_SPAN: span_q <= wr_data;
        REG_ERR_MV: err_mv_q <= wr_data;
        REG_STOP_HEAT: stop_heat_q <= wr_data;
        REG_STOP_COOL: stop_cool_q <= wr_data;
        REG_MASK: mask_q <= wr_data[EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Rate and limit banks: heat up, heat down, cool up, cool down; heat lo, heat hi, cool lo, cool hi
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        rate_q[i] <= RATE_RST;
        limit_q[i] <= i[0] ? LIMIT_HI_RST : LIMIT_LO_RST;
      end
    end
    else if (wr_en && addr[4:2] == REG_RATE_BASE[4:2])
      rate_q[addr[1:0]] <= wr_data;
    else if (wr_en && addr[4:2] == REG_LIMIT_BASE[4:2])
      limit_q[addr[1:0]] <= wr_data;
  end

  // Two-state hysteresis, reverse action
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      on_q <= 1'b0;
    else if (17'(measured_value) < 17'(set_value) - $signed({1'b0, gap_lo_eff}))
      on_q <= 1'b1;
    else if (17'(measured_value) > 17'(set_value) + $signed({1'b0, gap_up_eff}))
      on_q <= 1'b0;
  end

  // Input-error tracking; an error already present at the start of a run is not substituted
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      err_q <= 1'b0;
      run_q <= 1'b0;
      suppress_q <= 1'b0;
      err_side_q <= 2'b00;
    end
    else
    begin
      err_q <= err_now;
      run_q <= run;
      err_side_q <= {input_error_low, input_error_high};
      if (!err_now)
        suppress_q <= 1'b0;
      else if (run && !run_q)
        suppress_q <= 1'b1;
    end
  end

  always_comb
  begin
    heat_target = pid_heat;
    cool_target = pid_cool;
    if (valve && !fb_ok)
      heat_target = heat_side_output;
    else if (!run)
      heat_target = stop_heat_q;
    else if (manual)
      heat_target = manual_mv_q;
    else if (onoff_mode)
      heat_target = on_q ? MV_FULL : MV_ZERO;
    if (!run)
      cool_target = stop_cool_q;
    else if (onoff_mode)
      cool_target = MV_ZERO;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      follow_q <= 1'b0;
    else
      follow_q <= valve && !fb_ok && (!run || err_now);
  end
  assign valve_stop_follow = follow_q;

  rate_limiter u_heat (
    .clock(clock),
    .reset_n(reset_n),
    .sample(sample),
    .bypass(valve),
    .target(heat_target),
    .rise(rate_q[0]),
    .fall(rate_q[1]),
    .lo(limit_q[0]),
    .hi(limit_q[1]),
    .out_q(heat_side_output)
  );

  rate_limiter u_cool (
    .clock(clock),
    .reset_n(reset_n),
    .sample(sample),
    .bypass(valve),
    .target(cool_target),
    .rise(rate_q[2]),
    .fall(rate_q[3]),
    .lo(limit_q[2]),
    .hi(limit_q[3]),
    .out_q(cool_side_output)
  );

  // Sticky status, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      status_q <= '0;
    else
      status_q <= (status_q & ~(wr_hit(REG_STATUS) ? wr_data[EV_W-1:0] : '0)) | events;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end
  assign derivative_gain = dgain_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rd_data_q <= 16'h0000;
    else if (rd_en)
    begin
      rd_data_q <= 16'h0000;
      unique case (addr)
        REG_CTRL: rd_data_q <= 16'(ctrl_q);
        REG_STATUS: rd_data_q <= 16'(status_q);
        REG_MASK: rd_data_q <= 16'(mask_q);
        REG_DGAIN: rd_data_q <= dgain_q;
        REG_PB_HEAT: rd_data_q <= pb_heat_q;
        REG_GAP_UP: rd_data_q <= gap_up_eff;
        REG_GAP_LO: rd_data_q <= gap_lo_eff;
        REG_SPAN: rd_data_q <= span_q;
        REG_ERR_MV: rd_data_q <= err_mv_q;
        REG_STOP_HEAT: rd_data_q <= stop_heat_q;
        REG_STOP_COOL: rd_data_q <= stop_cool_q;
        REG_MANUAL_MV: rd_data_q <= manual_mv_q;
        REG_STATE: rd_data_q <= {12'h000, follow_q, suppress_q, on_q, onoff_mode};
        default:
        begin
          if (addr[4:2] == REG_RATE_BASE[4:2])
            rd_data_q <= rate_q[addr[1:0]];
          else if (addr[4:2] == REG_LIMIT_BASE[4:2])
            rd_data_q <= limit_q[addr[1:0]];
        end
      endcase
    end
  end
  assign rd_data = rd_data_q;

  AST_DGAIN_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
    dgain_q >= DGAIN_MIN && dgain_q <= DGAIN_MAX)
    else $error("derivative gain out of range");
  AST_HYST_ON: assert property (@(posedge clock) disable iff (!reset_n)
    17'(measured_value) < 17'(set_value) - $signed({1'b0, gap_lo_eff}) |=> on_q)
    else $error("two-state output did not turn on below lower gap");
  AST_HYST_KEEP: assert property (@(posedge clock) disable iff (!reset_n)
    measured_value == set_value && gap_lo_eff != 16'h0000 && gap_up_eff != 16'h0000 |=> on_q == $past(on_q))
    else $error("two-state output switched inside the gap");
  AST_SUBST: assert property (@(posedge clock) disable iff (!reset_n)
    subst |=> manual && manual_mv_q == $past(err_mv_q))
    else $error("input error did not enter manual with error value");
  AST_MANUAL_KEEP: assert property (@(posedge clock) disable iff (!reset_n)
    manual && err_now && !err_q && !wr_en |=> manual_mv_q == $past(manual_mv_q))
    else $error("manual output replaced on input error");
  AST_RUN_WITH_ERR: assert property (@(posedge clock) disable iff (!reset_n)
    run && !run_q && err_now |-> !subst ##1 (suppress_q || !err_now))
    else $error("substitution at start of run with error present");
  AST_STOP_HEAT: assert property (@(posedge clock) disable iff (!reset_n)
    (!run && !valve && rate_q[0] == 16'h0000 && rate_q[1] == 16'h0000
      && stop_heat_q >= $signed(limit_q[0]) && stop_heat_q <= $signed(limit_q[1]))[*3]
      |-> heat_side_output == $past(stop_heat_q))
    else $error("stopped heat output not at stop value");
  AST_ONOFF_FULL: assert property (@(posedge clock) disable iff (!reset_n)
    (run && !manual && !valve && onoff_mode && on_q && rate_q[0] == 16'h0000 && rate_q[1] == 16'h0000
      && $signed(limit_q[1]) >= $signed(MV_FULL) && $signed(limit_q[0]) <= $signed(MV_FULL))[*2]
      |-> heat_side_output == MV_FULL)
    else $error("two-state heat output not full on");
  COV_SUBST: cover property (@(posedge clock) disable iff (!reset_n) subst);
  COV_ONOFF: cover property (@(posedge clock) disable iff (!reset_n) onoff_mode && $rose(on_q));
  COV_STOP: cover property (@(posedge clock) disable iff (!reset_n) $fell(run));
  COV_IRQ: cover property (@(posedge clock) disable iff (!reset_n) $rose(irq));
endmodule

// ===== rtl/outcond_pkg.sv
// Purpose: constants for the output-conditioning stage of the process controller
// Assumes: outputs and rates in 0.1 % units, temperatures in input engineering units, 16-bit signed
// Notes: register indices sit on a plain 5-bit word-address port
package outcond_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  // Register word indices
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_MASK = 5'h02;
  localparam logic [4:0] REG_DGAIN = 5'h03;
  localparam logic [4:0] REG_PB_HEAT = 5'h04;
  localparam logic [4:0] REG_GAP_UP = 5'h05;
  localparam logic [4:0] REG_GAP_LO = 5'h06;
  localparam logic [4:0] REG_SPAN = 5'h07;
  localparam logic [4:0] REG_ERR_MV = 5'h08;
  localparam logic [4:0] REG_STOP_HEAT = 5'h09;
  localparam logic [4:0] REG_STOP_COOL = 5'h0a;
  localparam logic [4:0] REG_MANUAL_MV = 5'h0b;
  localparam logic [4:0] REG_RATE_BASE = 5'h0c;
  localparam logic [4:0] REG_LIMIT_BASE = 5'h10;
  localparam logic [4:0] REG_STATE = 5'h14;
  // Control register bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_VALVE = 2;
  localparam int CTRL_ANALOG = 3;
  localparam int CTRL_ACT_HIGH = 4;
  localparam int CTRL_ACT_LOW = 5;
  localparam int CTRL_W = 6;
  // Event bit positions in status and mask
  localparam int EV_ERR_HIGH = 0;
  localparam int EV_ERR_LOW = 1;
  localparam int EV_SUBST = 2;
  localparam int EV_ONOFF = 3;
  localparam int EV_W = 4;
  // Limits, scale constants and reset values
  localparam logic [15:0] DGAIN_MIN = 16'h0001;
  localparam logic [15:0] DGAIN_MAX = 16'h0064;
  localparam logic [15:0] DGAIN_RST = 16'h003c;
  localparam logic [15:0] PB_HEAT_RST = 16'h001e;
  localparam logic [15:0] GAP_RST = 16'h0001;
  localparam logic [15:0] SPAN_RST = 16'h0fa0;
  localparam logic [15:0] GAP_SPAN_DIV = 16'h03e8;
  localparam logic [15:0] ERR_MV_RST = 16'h0000;
  localparam logic [15:0] STOP_MV_RST = 16'hffce;
  localparam logic [15:0] MANUAL_MV_RST = 16'h0000;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] LIMIT_LO_RST = 16'hffce;
  localparam logic [15:0] LIMIT_HI_RST = 16'h041a;
  localparam logic [15:0] MV_FULL = 16'h03e8;
  localparam logic [15:0] MV_ZERO = 16'h0000;
  // Timing: rate settings are per second, so one step per second
  localparam int CLOCK_HZ = 10_000_000;
  localparam int SAMPLE_MS = 1000;
  localparam int SAMPLE_CYCLES = CLOCK_HZ / 1000 * SAMPLE_MS;
endpackage

// ===== rtl/rate_limiter.sv
// Purpose: per-output clamp to limits and step limit per sample
// Assumes: rates in 0.1 % per sample period, zero rate means no limiting
// Notes: updates every clock; a nonzero rate only moves the output on a sample pulse
`timescale 1ns/1ps
module rate_limiter
  import outcond_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic sample, // One-cycle sample pulse
  input wire logic bypass, // Ignore rate settings
  input wire logic signed [15:0] target, // Wanted output
  input wire logic [15:0] rise, // Rising step per sample
  input wire logic [15:0] fall, // Falling step per sample
  input wire logic signed [15:0] lo, // Low limit
  input wire logic signed [15:0] hi, // High limit
  output logic signed [15:0] out_q // Conditioned output
);
  logic signed [15:0] clamped;
  logic signed [16:0] up_lim;
  logic signed [16:0] dn_lim;
  logic signed [15:0] out_d;

  always_comb
  begin
    clamped = target;
    if (target > hi)
      clamped = hi;
    if (target < lo)
      clamped = lo;
    up_lim = 17'(out_q) + $signed({1'b0, rise});
    dn_lim = 17'(out_q) - $signed({1'b0, fall});
    out_d = clamped;
    if (!bypass && 17'(clamped) > 17'(out_q) && rise != 16'h0000)
    begin
      if (!sample)
        out_d = out_q;
      else if (17'(clamped) > up_lim)
        out_d = up_lim[15:0];
    end
    if (!bypass && 17'(clamped) < 17'(out_q) && fall != 16'h0000)
    begin
      if (!sample)
        out_d = out_q;
      else if (17'(clamped) < dn_lim)
        out_d = dn_lim[15:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      out_q <= MV_ZERO;
    else
      out_q <= out_d;
  end

  AST_STEP_UP: assert property (@(posedge clock) disable iff (!reset_n)
    sample && !bypass && rise != 16'h0000 && lo <= hi && 17'(clamped) > up_lim
      |=> out_q == $past(up_lim[15:0]))
    else $error("rising step not clamped to rate");
  AST_HOLD_BETWEEN: assert property (@(posedge clock) disable iff (!reset_n)
    !sample && !bypass && fall != 16'h0000 && 17'(clamped) < 17'(out_q) |=> out_q == $past(out_q))
    else $error("falling output moved between samples");
endmodule

// ===== bench/process_model.sv
// Purpose: sensor side of the loop, measured value and input-error levels
// Assumes: error points are fixed parameters of the measurement chain
// Notes: levels are registered, so they follow the command one edge late
`timescale 1ns/1ps
module process_model #(
  parameter logic signed [15:0] ERR_HI_P = 16'sd300,
  parameter logic signed [15:0] ERR_LO_P = 16'sd50
)
(
  input wire logic clock, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic signed [15:0] pv_cmd, // Wanted process value
  output logic signed [15:0] measured_value, // Measured value
  output logic input_error_high, // Past high error point
  output logic input_error_low // Past low error point
);
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      measured_value <= 16'sh0064;
      input_error_high <= 1'b0;
      input_error_low <= 1'b0;
    end
    else
    begin
      measured_value <= pv_cmd;
      input_error_high <= pv_cmd > ERR_HI_P;
      input_error_low <= pv_cmd < ERR_LO_P;
    end
  end
endmodule

// ===== bench/output_conditioning_tb_top.sv
// Purpose: self-checking bench for the output-conditioning stage
// Assumes: short sample period of 10 clocks
// Notes: drive tasks open on a clock edge; outputs are read 1 ns after an edge
`timescale 1ns/1ps
module output_conditioning_tb_top;
  import outcond_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic signed [15:0] pv = 16'sh0064;
  logic signed [15:0] set_value = 16'sh0064;
  logic signed [15:0] pid_heat = 16'sh0000;
  logic signed [15:0] pid_cool = 16'sh0000;
  logic fb_fit = 1'b0;
  logic fb_brk = 1'b0;
  logic signed [15:0] measured_value;
  logic err_hi;
  logic err_lo;
  logic [15:0] rd_data;
  logic signed [15:0] heat;
  logic signed [15:0] cool;
  logic [15:0] dgain;
  logic irq;
  logic follow;
  logic [15:0] v;
  int fails = 0;
  int compares = 0;
  always #50 clock = ~clock;
  process_model u_process_model (.clock(clock), .reset_n(reset_n), .pv_cmd(pv),
    .measured_value(measured_value), .input_error_high(err_hi), .input_error_low(err_lo));
  output_conditioning #(.SAMPLE_CYCLES_P(10)) u_output_conditioning (.clock(clock), .reset_n(reset_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .measured_value(measured_value),
    .set_value(set_value), .pid_heat(pid_heat), .pid_cool(pid_cool), .input_error_high(err_hi),
    .input_error_low(err_lo), .feedback_fitted(fb_fit), .feedback_broken(fb_brk), .rd_data(rd_data),
    .heat_side_output(heat), .cool_side_output(cool), .derivative_gain(dgain),
    .valve_stop_follow(follow), .irq(irq));
  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk16("rd_data", e, d);
  endtask
  task automatic set_pv(input logic signed [15:0] p, input logic signed [15:0] h);
    @(posedge clock);
    pv <= p;
    pid_heat <= h;
  endtask
  task automatic t_defaults();
    logic [4:0] a[9] = '{REG_DGAIN, REG_GAP_UP, REG_GAP_LO, REG_ERR_MV, REG_STOP_HEAT, REG_STOP_COOL,
      REG_RATE_BASE, REG_LIMIT_BASE + 5'h01, 5'h1f};
    logic [15:0] e[9] = '{DGAIN_RST, GAP_RST, GAP_RST, ERR_MV_RST, STOP_MV_RST, STOP_MV_RST,
      RATE_RST, LIMIT_HI_RST, 16'h0000};
    idle(3);
    chk16("derivative_gain", 16'h003c, dgain);
    chk16("heat stopped", 16'hffce, heat);
    chk16("cool stopped", 16'hffce, cool);
    foreach (a[i]) rdchk(a[i], e[i]);
    wr(REG_DGAIN, 16'h0000);
    rdchk(REG_DGAIN, 16'h0001);
    wr(REG_DGAIN, 16'h00c8);
    rdchk(REG_DGAIN, 16'h0064);
    chk16("derivative_gain", 16'h0064, dgain);
  endtask
  task automatic t_rate();
    set_pv(16'sh0064, 16'sh01f4);
    wr(REG_CTRL, 16'h0001);
    idle(3);
    chk16("heat prop", 16'h01f4, heat);
    wr(REG_LIMIT_BASE + 5'h01, 16'h0320);
    set_pv(16'sh0064, 16'sh03e8);
    idle(3);
    chk16("heat high clamp", 16'h0320, heat);
    wr(REG_RATE_BASE, 16'h0064);
    wr(REG_LIMIT_BASE + 5'h01, 16'h041a);
    set_pv(16'sh0064, 16'sh0000);
    idle(3);
    chk16("heat free fall", 16'h0000, heat);
    set_pv(16'sh0064, 16'sh03e8);
    idle(25);
    chk1("heat rise step", 1'b1, heat >= 16'sd200 && heat <= 16'sd300);
    idle(120);
    chk16("heat rise end", 16'h03e8, heat);
    set_pv(16'sh0064, 16'sh0000);
    fb_fit <= 1'b1;
    wr(REG_CTRL, 16'h0005);
    idle(3);
    set_pv(16'sh0064, 16'sh03e8);
    idle(3);
    chk16("heat valve mode", 16'h03e8, heat);
    chk1("valve follow running", 1'b0, follow);
    wr(REG_CTRL, 16'h0004);
    fb_brk <= 1'b1;
    idle(3);
    chk16("heat valve stop no feedback", 16'h03e8, heat);
    chk1("valve follow stopped", 1'b1, follow);
    set_pv(16'sh0064, 16'sh03e8);
    fb_brk <= 1'b0;
    idle(3);
    chk16("heat valve stop", 16'hffce, heat);
    chk1("valve follow good feedback", 1'b0, follow);
    wr(REG_CTRL, 16'h0001);
    wr(REG_RATE_BASE, 16'h0000);
  endtask
  task automatic t_two_state();
    logic signed [15:0] p[5] = '{16'sd200, 16'sd100, 16'sd98, 16'sd100, 16'sd102};
    logic [15:0] e[5] = '{16'h0000, 16'h0000, 16'h03e8, 16'h03e8, 16'h0000};
    wr(REG_PB_HEAT, 16'h0000);
    foreach (p[i])
    begin
      set_pv(p[i], 16'sh01f4);
      idle(3);
      chk16("heat two-state", e[i], heat);
      chk16("cool two-state", 16'h0000, cool);
    end
    rd(REG_STATE, v);
    chk1("two-state flag", 1'b1, v[0]);
    wr(REG_PB_HEAT, 16'h001e);
  endtask
  task automatic t_input_error();
    set_pv(16'sd200, 16'sh01f4);
    wr(REG_ERR_MV, 16'h012c);
    wr(REG_MASK, 16'h0007);
    wr(REG_CTRL, 16'h0031);
    set_pv(16'sd10, 16'sh01f4);
    idle(4);
    chk16("heat low error", 16'h012c, heat);
    wr(REG_STATUS, 16'h0007);
    wr(REG_CTRL, 16'h0011);
    set_pv(16'sd350, 16'sh01f4);
    idle(4);
    chk16("heat substituted", 16'h012c, heat);
    chk1("irq", 1'b1, irq);
    rdchk(REG_STATUS, 16'h000d);
    rdchk(REG_CTRL, 16'h0013);
    wr(REG_STATUS, 16'h0007);
    set_pv(16'sd200, 16'sh01f4);
    idle(3);
    chk1("irq cleared", 1'b0, irq);
    wr(REG_MASK, 16'h0000);
    wr(REG_MANUAL_MV, 16'h00c8);
    set_pv(16'sd350, 16'sh01f4);
    idle(4);
    chk16("heat manual", 16'h00c8, heat);
    chk1("irq masked", 1'b0, irq);
    rdchk(REG_STATUS, 16'h0009);
    wr(REG_CTRL, 16'h0010);
    wr(REG_CTRL, 16'h0011);
    idle(4);
    chk16("heat run with error", 16'h01f4, heat);
    rdchk(REG_CTRL, 16'h0011);
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    t_defaults();
    t_rate();
    t_two_state();
    t_input_error();
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    print_verdict();
  end
endmodule
